// ### osc_lock_pkg.sv
// Constants for the oscillator source control block with write lock.
// Assumes a 32-bit AXI4-Lite register bus and a 100 MHz system clock.
package osc_lock_pkg;

    localparam int         ADDR_W            = 8;
    localparam logic [7:0] UNLOCK_KEY_FIRST  = 8'he7;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'h18;
    localparam logic [7:0] OSC_CTRL_RESET    = 8'ha0;

    // Byte addresses of the registers
    localparam logic [ADDR_W-1:0] OSC_CTRL_ADDR   = 8'h00;
    localparam logic [ADDR_W-1:0] LOCK_STAT_ADDR  = 8'h04;
    localparam logic [ADDR_W-1:0] SCRATCH_ADDR    = 8'h08;
    localparam logic [ADDR_W-1:0] OPTION_ADDR     = 8'h0c;

    // Fields of the status word
    localparam int LOCK_STAT_STATE_LSB = 0;
    localparam int LOCK_STAT_OPTION    = 2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        LOCKED,
        GOT_FIRST,
        UNLOCKED
    } lock_state_t;

endpackage

// ### osc_lock_props.sv
// Checker for the locked oscillator source control block.
// Assumes it is bound to osc_source_control and sees only its ports.
`timescale 1ns/1ps
module osc_lock_chk
    import osc_lock_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic [7:0]  osc_source_control_reg
);
    logic [1:0] done_wr;
    // Writes completed since the last control update, saturating at two
    always_ff @(posedge aclk) begin
        if (!aresetn) done_wr <= 2'h0;
        else if ($changed(osc_source_control_reg)) done_wr <= 2'h0;
        else if ($rose(s_axi_bvalid) && done_wr != 2'h2) done_wr <= done_wr + 2'h1;
    end
    ////////////////////////////////////////////////////////////////////////
    reset_value_a: assert property (@(posedge aclk) !aresetn |=> osc_source_control_reg == OSC_CTRL_RESET)
        else $error("control register not at reset value");
    ctrl_on_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(osc_source_control_reg) |-> $rose(s_axi_bvalid))
        else $error("control register changed without a write");
    two_keys_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(osc_source_control_reg) |-> done_wr == 2'h2)
        else $error("control register changed without two key writes");
    bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    bresp_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0
        ($stable(osc_source_control_reg) || $rose(s_axi_bvalid)))
        else $error("read answer late or disturbed control");
    ctrl_cov_c: cover property (@(posedge aclk) $changed(osc_source_control_reg));
    err_cov_c: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    read_cov_c: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
endmodule // osc_lock_chk
bind osc_source_control osc_lock_chk chk (.*);

// ### osc_source_control.sv
// AXI4-Lite slave holding the oscillator source control register behind a
// two-key write lock, plus a status word, a scratch word and the option bit.
// Assumes a single clock aclk and synchronous active-low reset aresetn.
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps

module osc_source_control
    import osc_lock_pkg::*;
(
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic [2:0]         s_axi_awprot,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [ADDR_W-1:0]  s_axi_araddr,
    input  wire logic [2:0]         s_axi_arprot,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire logic               crystal_disable_option,
    output logic [7:0]              osc_source_control_reg
);

    ////////////////////////////////////////////////////////////////////////
    // Register map
    //   OSC_CTRL_ADDR   control byte, writable once after the two keys
    //   LOCK_STAT_ADDR  lock progress and the crystal option input
    //   SCRATCH_ADDR    free word, byte strobes honoured
    //   OPTION_ADDR     crystal option input alone
    //   Other addresses answer with a slave error and change nothing

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic              aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_held;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
        logic [7:0]        osc_ctrl;
        logic [31:0]       scratch;
    } regs_t;

    regs_t       cur;
    regs_t       next_cur;
    logic        ctrl_write;
    logic        ctrl_update;
    lock_state_t lock_state;
    logic        do_write;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a == OSC_CTRL_ADDR) || (a == LOCK_STAT_ADDR) ||
               (a == SCRATCH_ADDR) || (a == OPTION_ADDR);
    endfunction

    // Unmapped addresses answer with a slave error and have no effect
    function automatic logic [1:0] resp_for(input logic [ADDR_W-1:0] a);
        return is_mapped(a) ? RESP_OKAY : RESP_SLVERR;
    endfunction

    // Status word: lock progress in the low bits, option input above it
    function automatic logic [31:0] status_word(input lock_state_t st,
                                                input logic        xdis);
        logic [31:0] w;
        w                           = 32'h00000000;
        w[LOCK_STAT_STATE_LSB +: 2] = st;
        w[LOCK_STAT_OPTION]         = xdis;
        return w;
    endfunction

    // Byte-lane merge for the fully writable scratch word
    function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                                input logic [31:0] data,
                                                input logic [3:0]  strb);
        logic [31:0] w;
        w = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                w[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return w;
    endfunction

    // Read data for one address; unmapped addresses read as zero
    function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a,
                                              input logic [7:0]        ctrl,
                                              input logic [31:0]       scr,
                                              input lock_state_t       st,
                                              input logic              xdis);
        logic [31:0] w;
        case (a)
            OSC_CTRL_ADDR:  w = {24'h000000, ctrl};
            LOCK_STAT_ADDR: w = status_word(st, xdis);
            SCRATCH_ADDR:   w = scr;
            OPTION_ADDR:    w = {31'h0, xdis};
            default:        w = 32'h00000000;
        endcase
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Lock sequencer

    // Only writes carrying the low byte to the control word reach the lock
    assign do_write   = cur.aw_held && cur.w_held && !cur.bvalid;
    assign ctrl_write = do_write && (cur.aw_addr == OSC_CTRL_ADDR)
                        && cur.w_strb[0];

    osc_unlock_fsm u_lock (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .ctrl_write  (ctrl_write),
        .ctrl_wdata  (cur.w_data[7:0]),
        .ctrl_update (ctrl_update),
        .lock_state  (lock_state)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus handshakes

    assign s_axi_awready = !cur.aw_held;
    assign s_axi_wready  = !cur.w_held;
    assign s_axi_arready = !cur.rvalid;
    assign s_axi_bvalid  = cur.bvalid;
    assign s_axi_bresp   = cur.bresp;
    assign s_axi_rvalid  = cur.rvalid;
    assign s_axi_rresp   = cur.rresp;
    assign s_axi_rdata   = cur.rdata;
    assign osc_source_control_reg = cur.osc_ctrl;

    always_comb begin
        next_cur = cur;

        // Address and data may arrive in either order; each is held until the write completes
        if (s_axi_awvalid && !cur.aw_held) begin
            next_cur.aw_held = 1'b1;
            next_cur.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !cur.w_held) begin
            next_cur.w_held = 1'b1;
            next_cur.w_data = s_axi_wdata;
            next_cur.w_strb = s_axi_wstrb;
        end

        // Address and data both held: perform write, raise response.
        // A write waits for the previous response to drain, so answers stay in order.
        if (do_write) begin
            next_cur.aw_held = 1'b0;
            next_cur.w_held  = 1'b0;
            next_cur.bvalid  = 1'b1;
            next_cur.bresp   = resp_for(cur.aw_addr);
            if (ctrl_update) begin
                next_cur.osc_ctrl = cur.w_data[7:0];
            end
            if (cur.aw_addr == SCRATCH_ADDR) begin
                next_cur.scratch = merge_bytes(cur.scratch, cur.w_data, cur.w_strb);
            end
        end
        // Response clears once the master has taken it
        if (cur.bvalid && s_axi_bready) begin
            next_cur.bvalid = 1'b0;
        end

        // Reads never touch the lock sequencer
        if (s_axi_arvalid && !cur.rvalid) begin
            next_cur.rvalid = 1'b1;
            next_cur.rresp  = resp_for(s_axi_araddr);
            next_cur.rdata  = read_word(s_axi_araddr, cur.osc_ctrl, cur.scratch,
                                        lock_state, crystal_disable_option);
        end else if (cur.rvalid && s_axi_rready) begin
            next_cur.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur.aw_held  <= 1'b0;
            cur.aw_addr  <= '0;
            cur.w_held   <= 1'b0;
            cur.w_data   <= 32'h00000000;
            cur.w_strb   <= 4'h0;
            cur.bvalid   <= 1'b0;
            cur.bresp    <= RESP_OKAY;
            cur.rvalid   <= 1'b0;
            cur.rresp    <= RESP_OKAY;
            cur.rdata    <= 32'h00000000;
            cur.osc_ctrl <= OSC_CTRL_RESET;
            cur.scratch  <= 32'h00000000;
        end else begin
            cur <= next_cur;
        end
    end

endmodule // osc_source_control

// ### osc_unlock_fsm.sv
// Two-key unlock sequencer guarding one control register.
// Assumes ctrl_write pulses once per accepted write to that register only.
`timescale 1ns/1ps

module osc_unlock_fsm
    import osc_lock_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ctrl_write,
    input  wire logic [7:0]  ctrl_wdata,
    output logic             ctrl_update,
    output lock_state_t      lock_state
);

    typedef struct packed {
        lock_state_t st;
    } fsm_t;

    fsm_t cur;
    fsm_t next_cur;

    always_comb begin
        next_cur    = cur;
        ctrl_update = 1'b0;
        if (ctrl_write) begin
            case (cur.st)
                LOCKED: begin
                    if (ctrl_wdata == UNLOCK_KEY_FIRST) begin
                        next_cur.st = GOT_FIRST;
                    end
                end
                GOT_FIRST: begin
                    // Wrong second key drops the partial unlock
                    if (ctrl_wdata == UNLOCK_KEY_SECOND) begin
                        next_cur.st = UNLOCKED;
                    end else begin
                        next_cur.st = LOCKED;
                    end
                end
                UNLOCKED: begin
                    ctrl_update = 1'b1;
                    next_cur.st = LOCKED;
                end
                default: begin
                    next_cur.st = LOCKED;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur.st <= LOCKED;
        end else begin
            cur <= next_cur;
        end
    end

    assign lock_state = cur.st;

endmodule // osc_unlock_fsm

// ### testbench.sv
// Self-checking bench for the locked oscillator source control block.
// Assumes a 100 MHz clock and an AXI4-Lite master driven from here.
`timescale 1ns/1ps
module testbench;
    import osc_lock_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, ha, hw, hb;
    logic [7:0] awaddr = 0, araddr = 0, osc;
    logic [31:0] wdata = 0, rdata, rdat;
    logic [1:0] bresp, rresp, resp;
    logic xdis = 1'b1;
    logic [3:0] strb = 4'hf;
    int num_errors = 0, tests_run = 0;
    always #5 aclk = ~aclk;
    osc_source_control DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .crystal_disable_option(xdis), .osc_source_control_reg(osc));
    ////////////////////////////////////////////////////////////////////////
    task conclude;
        if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] stat(input lock_state_t s, input logic x);
        return (32'(s) << LOCK_STAT_STATE_LSB) | (32'(x) << LOCK_STAT_OPTION);
    endfunction
    task rst;
        aresetn <= 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(negedge aclk);
            ha = awready; hw = wready; hb = bvalid; resp = bresp;
            @(posedge aclk);
            if (ha) awvalid <= 0;
            if (hw) wvalid <= 0;
        end while (!hb);
        bready <= 0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(negedge aclk);
            ha = arready; hb = rvalid; rdat = rdata; resp = rresp;
            @(posedge aclk);
            if (ha) arvalid <= 0;
        end while (!hb);
        rready <= 0;
    endtask
    task t_order;
        wr(8'h00, 32'h18); wr(8'h00, 32'h33); wr(8'h00, 32'he7); wr(8'h00, 32'h33); wr(8'h00, 32'h18);
        chk(osc, OSC_CTRL_RESET);
        wr(8'h00, 32'he7); wr(8'h00, 32'h18); wr(8'h00, 32'h55);
        chk(osc, 32'h55);
        wr(8'h00, 32'h66);
        chk(osc, 32'h55);
    endtask
    task t_gap;
        wr(8'h00, 32'he7); rd(8'h04);
        chk(rdat, stat(GOT_FIRST, 1'b1));
        wr(8'h08, 32'ha5a5);
        chk(resp, RESP_OKAY);
        rd(8'h08);
        chk(rdat, 32'ha5a5);
        chk(resp, RESP_OKAY);
        rd(8'h0c);
        chk(rdat, 32'h1);
        wr(8'h00, 32'h18); wr(8'h00, 32'h3c);
        chk(osc, 32'h3c);
        rd(8'h04);
        chk(rdat, stat(LOCKED, 1'b1));
    endtask
    task t_reset;
        wr(8'h00, 32'he7); wr(8'h00, 32'h18); rst(); wr(8'h00, 32'h77);
        chk(osc, OSC_CTRL_RESET);
    endtask
    task t_bad;
        wr(8'h10, 32'h1);
        chk(resp, RESP_SLVERR);
        rd(8'h10);
        chk(rdat, 32'h0);
        chk(resp, RESP_SLVERR);
    endtask
    task t_strb;
        strb <= 4'he;
        wr(OSC_CTRL_ADDR, 32'he7);
        strb <= 4'hf;
        rd(LOCK_STAT_ADDR);
        chk(rdat, stat(LOCKED, 1'b1));
        strb <= 4'h3;
        wr(SCRATCH_ADDR, 32'h12345678);
        strb <= 4'hf;
        rd(SCRATCH_ADDR);
        chk(rdat, 32'h00005678);
    endtask
    task unlock_write(input logic [7:0] v);
        wr(OSC_CTRL_ADDR, 32'(UNLOCK_KEY_FIRST));
        wr(OSC_CTRL_ADDR, 32'(UNLOCK_KEY_SECOND));
        wr(OSC_CTRL_ADDR, 32'(v));
    endtask
    task t_sources;
        unlock_write(8'h81);
        chk(osc, 32'h81);
        rd(OPTION_ADDR);
        chk(rdat, 32'h1);
        unlock_write(8'h42);
        if (rdat[0]) begin
            repeat (20) @(posedge aclk);
        end
        unlock_write(8'h43);
        chk(osc, 32'h43);
        xdis <= 1'b0;
        rd(OPTION_ADDR);
        chk(rdat, 32'h0);
        rd(LOCK_STAT_ADDR);
        chk(rdat, stat(LOCKED, 1'b0));
        xdis <= 1'b1;
        unlock_write(8'h24);
        chk(osc, 32'h24);
        unlock_write(8'h18);
        chk(osc, 32'h18);
    endtask
    initial begin
        rst();
        chk(osc, OSC_CTRL_RESET);
        t_order(); t_gap(); t_strb(); t_reset(); t_sources(); t_bad();
        conclude();
    end
    initial begin
        #20000;
        num_errors++;
        conclude();
    end
endmodule // testbench
